// ===== inc/acc_pkg.sv
// Contract
// [R1] parallel modes drive pin as result bit 17
// [R2] config clock edge chosen by invert pin
// [R3] config bits taken only while select asserted
// [R4] busy high until result loaded
// [R5] host may use busy fall as ready
// [R6] bipolar and ten pins pick input range
// [R7] outputs enabled only when select and read low
// [R8] select gates slave serial data clock
// [R9] reset aborts running conversion
// [R10] reset zeroes data and clears config register; code loads 18'h20000 instead when the coding pin is low
// [R11] power-down refuses new conversions after current
// [R12] digital interface stays active in power-down
// [R13] convert start fall puts hold active
// [R14] convert start fall begins conversion, busy rises
// [R15] host shifts config msb first, one per edge
// [R16] software mode takes settings from config register
package acc_pkg;
  localparam int RESULT_BITS = 18;
  localparam int MSB_BIT = 17;
  localparam int CFG_BITS = 8;
  localparam int CFG_POS_TEN = 0;
  localparam int CFG_POS_BIPOLAR = 1;
  localparam int CFG_POS_PD = 2;
  localparam logic [CFG_BITS-1:0] CFG_RST = 8'h00;
  localparam logic [1:0] MODE_SERIAL = 2'h3;
  localparam logic [RESULT_BITS-1:0] RESULT_RST_OB = 18'h00000;
  localparam logic [RESULT_BITS-1:0] RESULT_SIGN = 18'h20000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = $clog2(CONV_CYCLES + 1);
  localparam int PIN_CNV = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_RD = 2;
  localparam int PIN_PD = 3;
  localparam int PIN_BIP = 4;
  localparam int PIN_TEN = 5;
  localparam int PIN_OB = 6;
  localparam int PIN_MODE0 = 7;
  localparam int PIN_MODE1 = 8;
  localparam int PIN_SRC = 9;
  localparam int PIN_EXT = 10;
  localparam int PIN_COUNT = 11;
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 11'h007;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_CONV = 3'b010,
    ACC_LOAD = 3'b100
  } acc_state_t;
  typedef enum logic [1:0] {
    ACC_RNG_0_5 = 2'b00,
    ACC_RNG_0_10 = 2'b01,
    ACC_RNG_PM5 = 2'b10,
    ACC_RNG_PM10 = 2'b11
  } acc_range_t;
endpackage

// ===== inc/acc_cfg_if.sv
interface acc_cfg_if #(parameter int CfgBits = acc_pkg::CFG_BITS);
  logic [CfgBits-1:0] word;
  logic toggle;
  modport shifter (output word, output toggle);
  modport core (input word, input toggle);
endinterface

// ===== design/acc_cfg_shift.sv
module acc_cfg_shift #(
  parameter int CfgBits = acc_pkg::CFG_BITS
) (
  input wire logic configSerialClock,
  input wire logic configClockEdgeInvert,
  input wire logic configSerialDataIn,
  input wire logic configPortSelectN,
  input wire logic nrst,
  input wire logic swModeCore,
  acc_cfg_if.shifter cfg
);
  import acc_pkg::*;
  localparam int CntW = $clog2(CfgBits + 1);
  typedef struct packed {
    logic [1:0] rstSync;
    logic [1:0] modeSync;
    logic [CfgBits-1:0] shift;
    logic [CntW-1:0] count;
    logic [CfgBits-1:0] word;
    logic toggle;
  } acc_link_t;
  acc_link_t q;
  acc_link_t d;
  logic linkClk;
  // active edge picked by the invert strap
  // [R2] edge select
  assign linkClk = configSerialClock ^ configClockEdgeInvert;
  always_comb begin
    d = q;
    d.rstSync = {q.rstSync[0], nrst};
    d.modeSync = {q.modeSync[0], swModeCore};
    if (!q.rstSync[1]) begin
      d.shift = '0;
      d.count = '0;
      d.word = CFG_RST;
      d.toggle = 1'b0;
    // [R3] select gates port
    end else if (q.modeSync[1] && !configPortSelectN) begin
      // [R15] msb first shift
      d.shift = {q.shift[CfgBits-2:0], configSerialDataIn};
      if (q.count == CntW'(CfgBits - 1)) begin
        d.word = {q.shift[CfgBits-2:0], configSerialDataIn};
        d.toggle = ~q.toggle;
        d.count = '0;
      end else begin
        d.count = q.count + 1'b1;
      end
    end
  end
  always_ff @(posedge linkClk) begin
    q <= d;
  end
  assign cfg.word = q.word;
  assign cfg.toggle = q.toggle;
  AST_CFG_GATED: assert property (@(posedge linkClk) disable iff (!q.rstSync[1]) // [R3]
    (q.toggle != d.toggle) |-> (!configPortSelectN && q.modeSync[1]))
    else $error("config word taken without select");
  AST_CFG_MSB: assert property (@(posedge linkClk) disable iff (!q.rstSync[1]) // [R15]
    (q.modeSync[1] && !configPortSelectN) |=> q.shift[0] == $past(configSerialDataIn))
    else $error("config bit not shifted in at lsb");
endmodule

// ===== design/acc_top.sv
module acc_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic convertStartN,
  input wire logic chipSelectN,
  input wire logic readN,
  input wire logic powerDownRequest,
  input wire logic rangeBipolarSelect,
  input wire logic rangeTenVoltSelect,
  input wire logic outputCodingSelect,
  input wire logic [1:0] modeSelect,
  input wire logic configSourceSelect,
  input wire logic extClockSelect,
  input wire logic [acc_pkg::RESULT_BITS-1:0] sampleCode,
  input wire logic configSerialClock,
  input wire logic configClockEdgeInvert,
  input wire logic configSerialDataIn,
  input wire logic parallelResultMsbIn,
  output logic parallelResultMsbOut,
  output logic parallelResultMsbOeN,
  output logic [acc_pkg::MSB_BIT-1:0] resultData,
  output logic resultOeN,
  output logic busy,
  output logic holdActive,
  output logic powerDownActive,
  output acc_pkg::acc_range_t rangeCode,
  output logic slaveClockEnable
);
  import acc_pkg::*;
  localparam int BusyMax = CONV_CYCLES + 3;

  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic cnvPrev;
    acc_state_t state;
    logic [CONV_CNT_W-1:0] count;
    logic [RESULT_BITS-1:0] result;
    logic [CFG_BITS-1:0] cfgReg;
    logic [1:0] tSync;
    logic tLast;
    logic primed;
    logic swMode;
    logic oeN;
    logic msbOeN;
    logic busy;
    logic hold;
    logic pdAct;
    acc_range_t range;
    logic slaveEn;
  } acc_core_t;

  acc_core_t q;
  acc_core_t d;
  logic [PIN_COUNT-1:0] pins;
  logic cnvFall;
  logic serialMode;
  logic pdEff;
  logic bipEff;
  logic tenEff;

  acc_cfg_if #(.CfgBits(CFG_BITS)) cfgBus ();

  acc_cfg_shift #(.CfgBits(CFG_BITS)) u_shift (
    .configSerialClock(configSerialClock),
    .configClockEdgeInvert(configClockEdgeInvert),
    .configSerialDataIn(configSerialDataIn),
    .configPortSelectN(parallelResultMsbIn),
    .nrst(nrst),
    .swModeCore(q.swMode),
    .cfg(cfgBus.shifter)
  );

  // apply output coding to an offset-binary code
  function automatic logic [RESULT_BITS-1:0] acc_code(
    input logic [RESULT_BITS-1:0] raw,
    input logic offsetBin
  );
    acc_code = offsetBin ? raw : (raw ^ RESULT_SIGN);
  endfunction

  always_comb begin
    pins = '0;
    pins[PIN_CNV] = convertStartN;
    pins[PIN_CS] = chipSelectN;
    pins[PIN_RD] = readN;
    pins[PIN_PD] = powerDownRequest;
    pins[PIN_BIP] = rangeBipolarSelect;
    pins[PIN_TEN] = rangeTenVoltSelect;
    pins[PIN_OB] = outputCodingSelect;
    pins[PIN_MODE0] = modeSelect[0];
    pins[PIN_MODE1] = modeSelect[1];
    pins[PIN_SRC] = configSourceSelect;
    pins[PIN_EXT] = extClockSelect;
  end

  always_comb begin
    serialMode = {q.s2[PIN_MODE1], q.s2[PIN_MODE0]} == MODE_SERIAL;
    cnvFall = q.cnvPrev && !q.s2[PIN_CNV];
    // [R16] software settings
    pdEff = q.swMode ? q.cfgReg[CFG_POS_PD] : q.s2[PIN_PD];
    bipEff = q.swMode ? q.cfgReg[CFG_POS_BIPOLAR] : q.s2[PIN_BIP];
    tenEff = q.swMode ? q.cfgReg[CFG_POS_TEN] : q.s2[PIN_TEN];
  end

  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.cnvPrev = q.s2[PIN_CNV];
    d.tSync = {q.tSync[0], cfgBus.toggle};
    d.swMode = serialMode && !q.s2[PIN_SRC];
    // [R7] bus enable gate
    d.oeN = q.s2[PIN_CS] || q.s2[PIN_RD];
    // [R1] msb pin driven
    d.msbOeN = q.s2[PIN_CS] || q.s2[PIN_RD] || serialMode;
    // [R8] slave clock gate
    d.slaveEn = serialMode && q.s2[PIN_EXT] && !q.s2[PIN_CS];
    // [R6] range select
    d.range = acc_range_t'({bipEff, tenEff});
    // [R12] interface stays live
    d.pdAct = pdEff && (q.state == ACC_IDLE);
    if (!q.primed) begin
      d.tLast = q.tSync[1];
      d.primed = 1'b1;
    end else if (q.tSync[1] != q.tLast) begin
      d.tLast = q.tSync[1];
      d.cfgReg = cfgBus.word;
    end
    unique case (q.state)
      ACC_IDLE: begin
        // [R11] refuse in power-down
        if (cnvFall && !pdEff) begin
          // [R13] hold on start
          d.hold = 1'b1;
          // [R14] start conversion
          d.busy = 1'b1;
          d.count = '0;
          d.state = ACC_CONV;
        end
      end
      ACC_CONV: begin
        if (q.count == CONV_CNT_W'(CONV_CYCLES - 1)) begin
          d.state = ACC_LOAD;
          d.hold = 1'b0;
        end else begin
          d.count = q.count + 1'b1;
        end
      end
      ACC_LOAD: begin
        // [R4] busy drops on load
        d.result = acc_code(sampleCode, q.s2[PIN_OB]);
        d.busy = 1'b0;
        d.state = ACC_IDLE;
      end
    endcase
    if (!nrst) begin
      // [R9] abort conversion
      d.state = ACC_IDLE;
      d.busy = 1'b0;
      d.hold = 1'b0;
      d.count = '0;
      d.cnvPrev = 1'b1;
      // [R10] data zeroed only with coding pin high, else 18'h20000; clear config
      d.result = acc_code(RESULT_RST_OB, q.s2[PIN_OB]);
      d.cfgReg = CFG_RST;
      d.primed = 1'b0;
      d.tLast = 1'b0;
      d.swMode = 1'b0;
      d.oeN = 1'b1;
      d.msbOeN = 1'b1;
      d.pdAct = 1'b0;
      d.slaveEn = 1'b0;
      d.range = ACC_RNG_0_5;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  assign parallelResultMsbOut = q.result[MSB_BIT];
  assign parallelResultMsbOeN = q.msbOeN;
  assign resultData = q.result[MSB_BIT-1:0];
  assign resultOeN = q.oeN;
  assign busy = q.busy;
  assign holdActive = q.hold;
  assign powerDownActive = q.pdAct;
  assign rangeCode = q.range;
  assign slaveClockEnable = q.slaveEn;

  default clocking acc_cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  AST_BUSY_RISE: assert property ( // [R14]
    (q.state == ACC_IDLE && cnvFall && !pdEff) |=> busy && q.state == ACC_CONV)
    else $error("busy did not rise on start");
  AST_HOLD_START: assert property ( // [R13]
    $rose(busy) |-> holdActive)
    else $error("hold not active at conversion start");
  AST_BUSY_BOUND: assert property ( // [R4]
    $rose(busy) |-> busy ##[1:BusyMax] $fell(busy))
    else $error("busy length out of bound");
  AST_BUSY_LOAD: assert property ( // [R4]
    q.state == ACC_LOAD |=> !busy
      && {parallelResultMsbOut, resultData} == acc_code($past(sampleCode), $past(q.s2[PIN_OB])))
    else $error("result not loaded as busy falls");
  AST_PD_REFUSE: assert property ( // [R11]
    (q.state == ACC_IDLE && pdEff) |=> !busy)
    else $error("conversion started in power-down");
  AST_PD_FINISH: assert property ( // [R11]
    (busy && pdEff) |=> busy || q.state == ACC_IDLE)
    else $error("running conversion not completed");
  AST_OE: assert property ( // [R7]
    (!q.s2[PIN_CS] && !q.s2[PIN_RD]) |=> !resultOeN)
    else $error("bus not enabled on select and read");
  AST_OE_OFF: assert property ( // [R7]
    (q.s2[PIN_CS] || q.s2[PIN_RD]) |=> resultOeN && parallelResultMsbOeN)
    else $error("bus driven without select and read");
  AST_MSB_SERIAL: assert property ( // [R1]
    serialMode |=> parallelResultMsbOeN)
    else $error("msb pin driven in serial mode");
  AST_PD_LIVE: assert property ( // [R12]
    (powerDownActive && !q.s2[PIN_CS] && !q.s2[PIN_RD]) |=> !resultOeN)
    else $error("interface dead in power-down");
  AST_SLAVE: assert property ( // [R8]
    (serialMode && q.s2[PIN_EXT]) |=> slaveClockEnable == !$past(q.s2[PIN_CS]))
    else $error("slave clock not gated by select");
  AST_RANGE_SW: assert property ( // [R16]
    q.swMode |=> rangeCode == acc_range_t'({$past(q.cfgReg[CFG_POS_BIPOLAR]), $past(q.cfgReg[CFG_POS_TEN])}))
    else $error("range not from config register");
  AST_RANGE_HW: assert property ( // [R6]
    !q.swMode |=> rangeCode == acc_range_t'({$past(q.s2[PIN_BIP]), $past(q.s2[PIN_TEN])}))
    else $error("range not from pins");
  AST_RESET: assert property (@(posedge core_clk) disable iff (1'b0) // [R9]
    !nrst |=> !busy && !holdActive && q.state == ACC_IDLE && q.cfgReg == CFG_RST)
    else $error("reset did not abort");
  AST_RESET_OB: assert property (@(posedge core_clk) disable iff (1'b0) // [R10]
    (!nrst && q.s2[PIN_OB]) |=> resultData == '0 && !parallelResultMsbOut)
    else $error("reset did not zero data");

  COV_CONV: cover property ($fell(busy));
  COV_PD_REFUSED: cover property (q.state == ACC_IDLE && cnvFall && pdEff);
  COV_CFG_TAKEN: cover property (q.primed && q.tSync[1] != q.tLast);
  COV_READ: cover property (!resultOeN && powerDownActive);
endmodule

// ===== testbench/acc_cfg_host.sv
module acc_cfg_host (
  output logic sclk,
  output logic sdi,
  output logic selN,
  output logic inv
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    inv = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
    selN = 1'b1;
  end
  // clocks with the port deselected, data ones
  task automatic idle_clk(input int n, input logic v);
    {inv, sclk} <= {v, v};
    sdi = 1'b1;
    for (int i = 0; i < n; i++) begin
      #3 sclk = ~sclk;
      #3 sclk = ~sclk;
    end
  endtask
  // first transition from idle level is the active edge
  // select held low over the frame
  // msb first, one bit per edge
  task automatic send(input logic [7:0] w, input logic v);
    idle_clk(4, v);
    #3 selN = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi = w[i];
      #3 sclk = ~sclk;
      #3 sclk = ~sclk;
    end
    #3 selN = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

// ===== testbench/adc_control_and_config_pins_tb_top.sv
module adc_control_and_config_pins_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acc_pkg::*;
  `define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
  int mismatches = 0;
  int n_checks = 0;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic cnvN = 1'b1, csN = 1'b1, rdN = 1'b1, pd = 1'b0, bip = 1'b0, range_ten_volt_select = 1'b0, ob = 1'b1;
  logic src = 1'b1, ext = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [17:0] code = 18'h00000;
  logic [31:0] seed = 32'h383D6508;
  logic sclk, sdi, selN, inv, pin17, msbOut, msbOeN, resOeN, busy, hold, pdAct, slvEn;
  logic [16:0] resData;
  acc_range_t rng;
  assign pin17 = msbOeN ? selN : msbOut;
  always #4 core_clk = ~core_clk;
  acc_cfg_host host (.sclk(sclk), .sdi(sdi), .selN(selN), .inv(inv));
  acc_top dut (.core_clk(core_clk), .nrst(nrst), .convertStartN(cnvN), .chipSelectN(csN),
    .readN(rdN), .powerDownRequest(pd), .rangeBipolarSelect(bip), .rangeTenVoltSelect(range_ten_volt_select),
    .outputCodingSelect(ob), .modeSelect(mode), .configSourceSelect(src), .extClockSelect(ext),
    .sampleCode(code), .configSerialClock(sclk), .configClockEdgeInvert(inv),
    .configSerialDataIn(sdi), .parallelResultMsbIn(pin17), .parallelResultMsbOut(msbOut),
    .parallelResultMsbOeN(msbOeN), .resultData(resData), .resultOeN(resOeN), .busy(busy),
    .holdActive(hold), .powerDownActive(pdAct), .rangeCode(rng), .slaveClockEnable(slvEn));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [17:0] exp_res(input logic [17:0] c, input logic o);
    return o ? c : c ^ RESULT_SIGN;
  endfunction
  task automatic start_pulse();
    cnvN = 1'b0;
    step(2);
    cnvN = 1'b1;
  endtask
  task automatic convert(input logic dbl);
    int nb, nh;
    nb = 0;
    nh = 0;
    seed = xs(seed);
    code = seed[17:0];
    ob = seed[20];
    mode = seed[22:21] % 2'h3;
    step(4);
    start_pulse();
    while (busy !== 1'b1 && nb < 10) begin
      step(1);
      nb++;
    end
    `CHK(busy, 1'b1)
    nb = 0;
    while (busy === 1'b1 && nb < 500) begin
      if (nb == 100 && dbl) cnvN = 1'b0;
      if (nb == 102) cnvN = 1'b1;
      if (hold === 1'b1) nh++;
      nb++;
      step(1);
    end
    `CHK(nb, 376)
    `CHK(nh, 375)
    csN = 1'b0;
    rdN = 1'b0;
    step(4);
    `CHK(msbOeN, 1'b0)
    // busy fall taken as data ready
    `CHK({msbOut, resData}, exp_res(code, ob))
    csN = 1'b1;
    rdN = 1'b1;
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    step(20000);
    mismatches++;
    report_and_stop;
  end
  initial begin
    fork
      host.idle_clk(40, 1'b0);
    join_none
    step(9);
    `CHK({msbOut, resData}, 18'h00000)
    step(1);
    nrst = 1'b1;
    step(2);
    for (int k = 0; k < 4; k++) begin
      {bip, range_ten_volt_select} = k[1:0];
      step(5);
      `CHK(rng, acc_range_t'(k[1:0]))
    end
    for (int k = 0; k < 4; k++) begin
      {csN, rdN} = k[1:0];
      step(4);
      `CHK(resOeN, (k != 0))
    end
    repeat (4) convert(1'b0);
    convert(1'b1);
    start_pulse();
    step(60);
    nrst = 1'b0;
    step(3);
    `CHK(busy, 1'b0)
    `CHK(hold, 1'b0)
    nrst = 1'b1;
    step(3);
    convert(1'b0);
    pd = 1'b1;
    step(5);
    `CHK(pdAct, 1'b1)
    start_pulse();
    step(10);
    `CHK(busy, 1'b0)
    csN = 1'b0;
    rdN = 1'b0;
    step(4);
    `CHK({msbOut, resData}, exp_res(code, ob))
    {csN, rdN, pd, mode, ext} = {3'h2, 2'h3, 1'b1};
    step(4);
    `CHK(slvEn, 1'b1)
    `CHK(msbOeN, 1'b1)
    ext = 1'b0;
    step(4);
    `CHK(slvEn, 1'b0)
    {csN, bip, range_ten_volt_select, src} = 4'h2;
    step(4);
    host.send(8'h07, 1'b0);
    step(8);
    `CHK(rng, ACC_RNG_PM10)
    `CHK(pdAct, 1'b1)
    host.send(8'h02, 1'b1);
    step(8);
    `CHK(rng, ACC_RNG_PM5)
    `CHK(pdAct, 1'b0)
    src = 1'b1;
    step(5);
    `CHK(rng, ACC_RNG_0_10)
    report_and_stop;
  end
endmodule
